// file: src/adcbg_top.sv
// Converter input select, bandgap control and converter clock divider.
// Assumes a register master on I_SYS_CLK with one-cycle strobes.
//
// Summary of operation
// - Input select routes internal reference inward when bandgap enabled
// - Input select cuts off all external channels
// - Bandgap enable offers reference to converter
// - Bandgap powers down when nobody needs it
// - Reference select picks supply or reference pin
// - Clock field divides system clock, 111 stops
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module adcbg_top (
    // Clock and reset
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_ARST_N,
    // Register port
    input  wire logic [1:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    // Protection circuit enables from pins
    input  wire logic       I_LOW_VOLTAGE_RESET_EN,
    input  wire logic       I_LOW_VOLTAGE_DETECT_EN,
    // Converter analog controls
    output logic            O_BANDGAP_POWER,
    output logic            O_BANDGAP_TO_CONV,
    output logic            O_EXT_CHANNELS_EN,
    output logic            O_REF_FROM_PIN,
    output logic            O_CONV_CLK_EN,
    output logic            O_BANDGAP_SETTLED
);
    logic [7:0] ctrl_r;
    logic [7:0] rdata_r;
    logic [1:0] lvr_sync_r;
    logic [1:0] lvd_sync_r;
    logic [7:0] settle_r;
    logic [7:0] settle_nxt;
    logic       sel_bg;
    logic       bg_en;
    logic       bg_power;
    logic [7:0] status;
    logic [7:0] rd_mux;
    logic       ctrl_hit;
    logic       status_hit;
    logic       wr_ctrl;
    logic [7:0] on_cnt_r;
    logic [7:0] on_cnt_nxt;

    // The settle count as an 8-bit value, for the checks below.
    localparam logic [7:0] SETTLE_CYC8 = 8'(adcbg_pkg::BG_SETTLE_CYC);

    // ************************************************************
    // Address decoding
    // ************************************************************
    // One decoder serves the write path, the read mux and some checks;
    // a_ref_select and a_read_timing compare I_ADDR to the package address directly.
    function automatic logic addr_is(input logic [1:0] addr,
                                     input logic [1:0] target);
        addr_is = (addr == target);
    endfunction

    assign ctrl_hit   = addr_is(I_ADDR, adcbg_pkg::ADC_CONTROL_1_ADDR);
    assign status_hit = addr_is(I_ADDR, adcbg_pkg::STATUS_ADDR);
    assign wr_ctrl    = I_WR & ctrl_hit;

    // ************************************************************
    // Decoding
    // ************************************************************
    assign sel_bg   = ctrl_r[adcbg_pkg::INPUT_SEL_BIT];
    assign bg_en    = ctrl_r[adcbg_pkg::BG_ENABLE_BIT];
    // The reference stays up while either protection circuit needs it.
    assign bg_power = bg_en | lvr_sync_r[1] | lvd_sync_r[1];
    assign status   = {5'h00, (settle_r == 8'h00) & bg_power,
                       lvd_sync_r[1], lvr_sync_r[1]};
    assign rd_mux   = ctrl_hit ? ctrl_r :
                      status_hit ? status : 8'h00;
    assign settle_nxt = !bg_power ? 8'(adcbg_pkg::BG_SETTLE_CYC) :
                        (settle_r != 8'h00) ? settle_r - 8'h01 : 8'h00;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_r <= adcbg_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= I_WDATA & adcbg_pkg::CTRL_RW_MASK;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= I_RD ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lvr_sync_r <= 2'h0;
            lvd_sync_r <= 2'h0;
            settle_r   <= 8'(adcbg_pkg::BG_SETTLE_CYC);
        end else begin
            lvr_sync_r <= {lvr_sync_r[0], I_LOW_VOLTAGE_RESET_EN};
            lvd_sync_r <= {lvd_sync_r[0], I_LOW_VOLTAGE_DETECT_EN};
            settle_r   <= settle_nxt;
        end
    end

    adcbg_clkdiv u_div (
        .i_clk     (I_SYS_CLK),
        .i_arst_n  (I_ARST_N),
        .i_div_sel (ctrl_r[adcbg_pkg::CLK_DIV_MSB:0]),
        .o_clk_en  (O_CONV_CLK_EN)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign O_RDATA           = rdata_r;
    assign O_BANDGAP_POWER   = bg_power;
    // Selecting without enabling yields no reference; software's duty.
    assign O_BANDGAP_TO_CONV = sel_bg & bg_en;
    assign O_EXT_CHANNELS_EN = ~sel_bg;
    assign O_REF_FROM_PIN    = ctrl_r[adcbg_pkg::REF_SEL_BIT];
    assign O_BANDGAP_SETTLED = status[2];

    // ************************************************************
    // Checks
    // ************************************************************
    a_sel_cuts_ext: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) sel_bg |-> !O_EXT_CHANNELS_EN)
        else $error("external channels still connected");
    a_sel_routes_bg: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (sel_bg && bg_en) |-> O_BANDGAP_TO_CONV)
        else $error("bandgap not routed");
    a_no_bg_unenabled: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) !bg_en |-> !O_BANDGAP_TO_CONV)
        else $error("bandgap offered while disabled");
    a_bg_power_down: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (!bg_en && !lvr_sync_r[1] && !lvd_sync_r[1])
        |-> !O_BANDGAP_POWER)
        else $error("bandgap powered without user");
    a_ref_select: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (I_WR && I_ADDR == adcbg_pkg::ADC_CONTROL_1_ADDR)
        |=> O_REF_FROM_PIN == $past(I_WDATA[4]))
        else $error("reference select wrong");
    a_undef_stops: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (ctrl_r[2:0] == 3'h7)[*2] |-> !O_CONV_CLK_EN)
        else $error("clock runs on undefined code");
    a_div_one: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (ctrl_r[2:0] == 3'h0)[*2] |-> O_CONV_CLK_EN)
        else $error("divide by one not every cycle");
    a_unused_zero: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (ctrl_r & 8'h28) == 8'h00)
        else $error("unimplemented bit set");
    a_read_timing: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (I_RD && I_ADDR == adcbg_pkg::ADC_CONTROL_1_ADDR)
        |=> O_RDATA == $past(ctrl_r))
        else $error("read data wrong");
    a_settle_wait: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) $rose(bg_power) |=> !O_BANDGAP_SETTLED)
        else $error("settled too early");

    // ************************************************************
    // Check helpers
    // ************************************************************
    // Counts cycles of unbroken reference power, independent of the
    // settle counter, so the settle checks do not mirror the design.
    assign on_cnt_nxt = !bg_power ? 8'h00 :
                        (on_cnt_r == 8'hff) ? 8'hff : on_cnt_r + 8'h01;

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            on_cnt_r <= 8'h00;
        end else begin
            on_cnt_r <= on_cnt_nxt;
        end
    end

    sequence s_code_half;
        (ctrl_r[2:0] == 3'h1)[*3];
    endsequence

    sequence s_power_long;
        bg_power && (on_cnt_r >= SETTLE_CYC8);
    endsequence

    sequence s_power_short;
        on_cnt_r < SETTLE_CYC8;
    endsequence

    a_div_two: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) s_code_half |-> O_CONV_CLK_EN != $past(O_CONV_CLK_EN))
        else $error("divide by two not alternating");
    a_settle_done: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) s_power_long |-> O_BANDGAP_SETTLED)
        else $error("settled flag late");
    a_settle_early: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) s_power_short |-> !O_BANDGAP_SETTLED)
        else $error("settled flag early");
    a_ext_follow: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) !sel_bg |-> O_EXT_CHANNELS_EN)
        else $error("external channels cut without select");
    a_ctrl_mask: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) wr_ctrl |=>
        ctrl_r == ($past(I_WDATA) & adcbg_pkg::CTRL_RW_MASK))
        else $error("control write wrong");
    a_rdata_idle: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) !I_RD |=> O_RDATA == 8'h00)
        else $error("read data without read");
    a_status_upper: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) (I_RD && status_hit) |=> O_RDATA[7:3] == 5'h00)
        else $error("status unused bits set");
    a_lvr_two_flops: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) lvr_sync_r[1] == $past(I_LOW_VOLTAGE_RESET_EN, 2))
        else $error("reset enable sync wrong");
    a_lvd_two_flops: assert property (@(posedge I_SYS_CLK) disable iff
        (!I_ARST_N) lvd_sync_r[1] == $past(I_LOW_VOLTAGE_DETECT_EN, 2))
        else $error("detect enable sync wrong");
endmodule

// file: src/adcbg_pkg.sv
// Package for the converter input and bandgap control block.
// Assumes a single 100 MHz system clock and an 8-bit register port.
package adcbg_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [1:0] ADC_CONTROL_1_ADDR = 2'h0;
    localparam logic [1:0] STATUS_ADDR        = 2'h1;
    localparam int INPUT_SEL_BIT   = 7;
    localparam int BG_ENABLE_BIT   = 6;
    localparam int REF_SEL_BIT     = 4;
    localparam int CLK_DIV_MSB     = 2;
    localparam logic [7:0] CTRL_RW_MASK  = 8'hd7;
    localparam logic [7:0] CTRL_RESET    = 8'h00;

    // ************************************************************
    // Divider and settling timing
    // ************************************************************
    localparam int CLK_MHZ         = 100;
    localparam int BG_SETTLE_NS    = 1000;
    localparam int BG_SETTLE_CYC   = (BG_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] DIV_UNDEFINED = 3'h7;
    localparam logic [5:0] PRESCALE_RESET = 6'h00;

endpackage

// file: src/adcbg_clkdiv.sv
// Converter clock enable divider.
// Assumes one system clock; produces a one-cycle enable pulse.
`timescale 1ns/1ps
module adcbg_clkdiv (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // Control
    input  wire logic [2:0] i_div_sel,
    // Output
    output logic            o_clk_en
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [5:0] limit;
    logic       wrap;
    logic       en_r;

    // Code n divides by two to the n; the undefined code stops the clock.
    assign limit   = 6'((7'h01 << i_div_sel) - 7'h01);
    assign wrap    = (cnt_r >= limit);
    assign cnt_nxt = wrap ? adcbg_pkg::PRESCALE_RESET : cnt_r + 6'h01;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_r <= adcbg_pkg::PRESCALE_RESET;
            en_r  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            en_r  <= wrap && (i_div_sel != adcbg_pkg::DIV_UNDEFINED);
        end
    end

    assign o_clk_en = en_r;
endmodule

// file: testbench/test_adc_bandgap_input_control.sv
// Testbench for the converter input select and bandgap control block.
// Assumes the design top adcbg_top and the package adcbg_pkg.
`timescale 1ns/1ps
module test_adc_bandgap_input_control;
    logic       clk, rst_n, wr, rd, low_voltage_reset, low_voltage_detect;
    logic [1:0] addr;
    logic [7:0] wdata, rdata;
    logic       pwr, to_conv, ext_en, ref_pin, conv_en, settled;
    int         n_mismatch, samples_checked, i, n;
    adcbg_top u_dut (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_LOW_VOLTAGE_RESET_EN(low_voltage_reset), .I_LOW_VOLTAGE_DETECT_EN(low_voltage_detect),
        .O_BANDGAP_POWER(pwr), .O_BANDGAP_TO_CONV(to_conv),
        .O_EXT_CHANNELS_EN(ext_en), .O_REF_FROM_PIN(ref_pin),
        .O_CONV_CLK_EN(conv_en), .O_BANDGAP_SETTLED(settled));
    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic give_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0; #1;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0; #1;
        chk(rdata, e);
    endtask
    task automatic outs(input logic [4:0] e);
        chk({3'h0, pwr, to_conv, ext_en, ref_pin, settled}, {3'h0, e});
    endtask
    // Period between the second and third enable pulses; 0 means fewer than three in 300 cycles.
    task automatic per(input int e);
        int t[3];
        int k;
        k = 0;
        for (int j = 0; j < 300 && k < 3; j++) begin
            @(posedge clk); #1;
            if (conv_en === 1'b1) begin t[k] = j; k++; end
        end
        chk(8'(k < 3 ? 0 : t[2] - t[1]), 8'(e));
    endtask
    // ************************************************************
    // Clock, reset and sequence
    // ************************************************************
    initial begin clk = 1'b0; forever #5 clk = ~clk; end
    initial begin
        n_mismatch = 0; samples_checked = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; low_voltage_reset = 1'b0; low_voltage_detect = 1'b0;
        addr = 2'h0; wdata = 8'h00;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1; #1;
        outs(5'b00100);
        rd_chk(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'h00);
        wr_reg(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'hff);
        outs(5'b11010);
        rd_chk(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'hd7);
        wr_reg(adcbg_pkg::STATUS_ADDR, 8'h00);
        rd_chk(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'hd7);
        rd_chk(2'h2, 8'h00);
        wr_reg(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'h80);
        outs(5'b00000);
        wr_reg(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'h00);
        outs(5'b00100);
        @(posedge clk); low_voltage_reset <= 1'b1; repeat (4) @(posedge clk); #1;
        outs(5'b10100);
        rd_chk(adcbg_pkg::STATUS_ADDR, 8'h01);
        @(posedge clk); low_voltage_reset <= 1'b0; low_voltage_detect <= 1'b1; repeat (4) @(posedge clk);
        rd_chk(adcbg_pkg::STATUS_ADDR, 8'h02);
        @(posedge clk); low_voltage_detect <= 1'b0; repeat (4) @(posedge clk); #1;
        outs(5'b00100);
        wr_reg(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'h40);
        outs(5'b10100);
        n = 0;
        for (i = 0; i < 150 && settled !== 1'b1; i++) begin
            @(posedge clk); #1; n++;
        end
        if (i == 150) begin n_mismatch++; give_verdict(); end
        chk({7'h0, n >= 95 && n <= 105}, 8'h01);
        rd_chk(adcbg_pkg::STATUS_ADDR, 8'h04);
        // Enable already set and settled, now select the reference.
        wr_reg(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'hc0);
        outs(5'b11001);
        // Second reset in mid-run must bring back every reset value.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        outs(5'b00100);
        rd_chk(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr_reg(adcbg_pkg::ADC_CONTROL_1_ADDR, 8'(c));
            per(c == 7 ? 0 : 1 << c);
        end
        give_verdict();
    end
endmodule
